// file: core/cfts_params.svh
// Timing constants, field widths and reset values for the frame transmit scheduler
`ifndef CFTS_PARAMS_SVH
`define CFTS_PARAMS_SVH
`define CFTS_CLK_HZ 10000000
`define CFTS_TICK_US 500
`define CFTS_TICK_CYCLES ((`CFTS_CLK_HZ / 1000000) * `CFTS_TICK_US)
`define CFTS_DEF_INTERVAL_MS 100
`define CFTS_DEF_INTERVAL_TICKS 16'h00C8
`define CFTS_STD_ID_MAX 29'h0000_07FF
`define CFTS_EXT_ID_MAX 29'h1FFF_FFFF
`define CFTS_MAX_LEN 4'h8
`define CFTS_ID_W 29
`define CFTS_IVL_W 16
`define CFTS_DEF_TIMING 3'h1
`endif

// file: core/cfts_pkg.sv
// Types shared by the frame transmit scheduler
`default_nettype none
package cfts_pkg;
  typedef enum logic [2:0] {
    CFTS_CYC_DATA = 3'h0,
    CFTS_EVT_DATA = 3'h1,
    CFTS_CYC_REM = 3'h2,
    CFTS_EVT_REM = 3'h3,
    CFTS_CYC_EVT = 3'h4
  } cfts_timing_t;
  typedef enum logic [2:0] {
    CFTS_IDLE = 3'b001,
    CFTS_BUSY = 3'b010,
    CFTS_GAP = 3'b100
  } cfts_state_t;
endpackage
`default_nettype wire

// file: core/cfts_tick_gen.sv
// Free running 500 us tick generator
`include "cfts_params.svh"
`default_nettype none
module cfts_tick_gen (
  input wire logic core_clk_i, // System clock
  input wire logic rst_i,      // Synchronous reset
  output logic tick_o          // One-cycle pulse per tick
);
  localparam int unsigned TC = `CFTS_TICK_CYCLES;
  logic [12:0] cnt_r;
  logic [12:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  always_comb begin
    tick_nxt = (cnt_r == 13'(TC - 1));
    cnt_nxt = tick_nxt ? 13'h0000 : cnt_r + 13'h0001;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_r <= 13'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick_o = tick_r;
endmodule
`default_nettype wire

// file: core/cfts_cfg_check.sv
// Frame configuration validity check
`include "cfts_params.svh"
`default_nettype none
module cfts_cfg_check (
  input wire logic core_clk_i,                 // System clock
  input wire logic rst_i,                      // Synchronous reset
  input wire logic extended_id_select_i,       // Identifier width select
  input wire logic [`CFTS_ID_W-1:0] frame_id_i, // Arbitration identifier
  input wire logic [3:0] payload_len_i,        // Payload length
  input wire logic [2:0] frame_timing_type_i,  // Timing type code
  input wire logic [`CFTS_IVL_W-1:0] ivl_i,    // Interval in ticks
  output logic cfg_ok_o                        // Configuration valid
);
  logic ok_r;
  logic ok_nxt;
  always_comb begin
    ok_nxt = 1'b1;
    if (!extended_id_select_i && frame_id_i > `CFTS_STD_ID_MAX) ok_nxt = 1'b0; // [RULE17] [RULE1]
    if (extended_id_select_i && frame_id_i > `CFTS_EXT_ID_MAX) ok_nxt = 1'b0; // [RULE17]
    if (payload_len_i > `CFTS_MAX_LEN) ok_nxt = 1'b0; // [RULE18]
    if (frame_timing_type_i > 3'h4) ok_nxt = 1'b0; // [RULE2]
    if ((frame_timing_type_i == 3'h0 || frame_timing_type_i == 3'h2 ||
         frame_timing_type_i == 3'h4) && ivl_i == 16'h0000) ok_nxt = 1'b0; // [RULE11]
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) ok_r <= 1'b0;
    else ok_r <= ok_nxt;
  end
  assign cfg_ok_o = ok_r;
endmodule
`default_nettype wire

// file: core/cfts_sched.sv
// Per-frame CAN transmit scheduler top level
`include "cfts_params.svh"
`default_nettype none
// What this block does
// [RULE1] Identifier is 11-bit standard when extended select low, else 29-bit.
// [RULE2] Timing codes: 0 cyc data, 1 evt data, 2 cyc rem, 3 evt rem, 4 both.
// [RULE3] Cyclic data sends the data frame every interval.
// [RULE4] Data modes ignore received remote requests.
// [RULE5] Event data sends on write, interval is minimum spacing.
// [RULE6] Cyclic remote: requester sends remote frames every interval.
// [RULE7] Event remote: requester sends remote frame on write, with minimum spacing.
// [RULE8] Remote modes answer every received remote request with data frame.
// [RULE9] Cyclic/event sends on write and every period, no spacing.
// [RULE10] Interval is counted in 500 us steps.
// [RULE11] Zero interval is invalid for cyclic modes.
// [RULE12] Spacing measured from acknowledgment of previous frame.
// [RULE13] Zero interval in event modes allows back to back frames.
// [RULE14] Default interval is 0.1 s.
// [RULE15] Default timing type is event data.
// [RULE16] Early write is held and sent after spacing with latest payload.
// [RULE17] Standard id above 0x7FF or extended above 0x1FFFFFFF is invalid.
// [RULE18] Payload length above 8 bytes is invalid.
module cfts_sched (
  input wire logic core_clk_i,                   // System clock, 10 MHz
  input wire logic rst_i,                        // Synchronous reset, active high
  input wire logic cfg_use_default_i,            // Use default timing and interval
  input wire logic extended_id_select_i,         // Extended identifier select
  input wire logic [`CFTS_ID_W-1:0] frame_id_i,  // Arbitration identifier
  input wire logic [2:0] frame_timing_type_i,    // Timing type code
  input wire logic [`CFTS_IVL_W-1:0] frame_interval_time_i, // Interval, 500 us units
  input wire logic [3:0] payload_len_i,          // Payload length in bytes
  input wire logic wr_evt_i,                     // Local write event pulse
  input wire logic [63:0] wr_data_i,             // Payload with write event
  input wire logic rtr_rx_i,                     // Remote request received pulse
  input wire logic tx_ack_i,                     // Frame acknowledged pulse
  output logic tx_req_o,                         // Frame request level until ack
  output logic tx_remote_o,                      // Requested frame is remote
  output logic tx_ext_o,                         // Requested frame uses 29-bit id
  output logic [`CFTS_ID_W-1:0] tx_id_o,         // Requested identifier
  output logic [3:0] tx_len_o,                   // Requested payload length
  output logic [63:0] tx_data_o,                 // Requested payload
  output logic cfg_ok_o                          // Configuration valid
);
  logic tick;
  logic cfg_ok;
  cfts_pkg::cfts_timing_t mode;
  logic [`CFTS_IVL_W-1:0] ivl;
  cfts_pkg::cfts_state_t st_r, st_nxt;
  logic [`CFTS_IVL_W-1:0] per_r, per_nxt;
  logic [`CFTS_IVL_W-1:0] gap_r, gap_nxt;
  logic pend_r, pend_nxt;
  logic pend_rem_r, pend_rem_nxt;
  logic ans_r, ans_nxt;
  logic [63:0] pay_r, pay_nxt;
  logic req_r, req_nxt;
  logic rem_r, rem_nxt;
  logic ext_r, ext_nxt;
  logic [`CFTS_ID_W-1:0] id_r, id_nxt;
  logic [3:0] len_r, len_nxt;
  logic [63:0] txd_r, txd_nxt;
  logic cyc_due;
  logic is_evt;
  logic has_gap;

  cfts_tick_gen u_tick (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  cfts_cfg_check u_chk (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .extended_id_select_i(extended_id_select_i),
    .frame_id_i(frame_id_i),
    .payload_len_i(payload_len_i),
    .frame_timing_type_i(mode),
    .ivl_i(ivl),
    .cfg_ok_o(cfg_ok)
  );

  always_comb begin
    mode = cfts_pkg::cfts_timing_t'(frame_timing_type_i);
    ivl = frame_interval_time_i;
    if (cfg_use_default_i) begin
      mode = cfts_pkg::cfts_timing_t'(`CFTS_DEF_TIMING); // [RULE15]
      ivl = `CFTS_DEF_INTERVAL_TICKS; // [RULE14] [RULE10]
    end
  end

  // Spacing applies only to the event modes; the combined mode has none
  assign is_evt = (mode == cfts_pkg::CFTS_EVT_DATA) || (mode == cfts_pkg::CFTS_EVT_REM);
  assign has_gap = is_evt && (ivl != 16'h0000); // [RULE13]
  assign cyc_due = tick && (per_r <= 16'h0001);

  always_comb begin
    st_nxt = st_r;
    per_nxt = per_r;
    gap_nxt = gap_r;
    pend_nxt = pend_r;
    pend_rem_nxt = pend_rem_r;
    ans_nxt = ans_r;
    pay_nxt = pay_r;
    req_nxt = req_r;
    rem_nxt = rem_r;
    ext_nxt = ext_r;
    id_nxt = id_r;
    len_nxt = len_r;
    txd_nxt = txd_r;
    if (wr_evt_i) begin
      pay_nxt = wr_data_i; // [RULE16] [RULE9]
    end
    // Period counter runs in 500 us steps regardless of bus state
    if (tick) begin
      per_nxt = (per_r <= 16'h0001) ? ivl : per_r - 16'h0001; // [RULE10]
    end
    if (cfg_ok) begin
      unique case (mode)
        cfts_pkg::CFTS_CYC_DATA: if (cyc_due) pend_nxt = 1'b1; // [RULE3] [RULE4]
        cfts_pkg::CFTS_EVT_DATA: if (wr_evt_i) pend_nxt = 1'b1; // [RULE5] [RULE4]
        cfts_pkg::CFTS_CYC_REM: begin
          if (cyc_due) pend_rem_nxt = 1'b1; // [RULE6]
          if (rtr_rx_i) ans_nxt = 1'b1; // [RULE8]
        end
        cfts_pkg::CFTS_EVT_REM: begin
          if (wr_evt_i) pend_rem_nxt = 1'b1; // [RULE7]
          if (rtr_rx_i) ans_nxt = 1'b1; // [RULE8]
        end
        cfts_pkg::CFTS_CYC_EVT: if (wr_evt_i || cyc_due) pend_nxt = 1'b1; // [RULE9]
        default: begin
          pend_nxt = 1'b0;
        end
      endcase
    end else begin
      pend_nxt = 1'b0;
      pend_rem_nxt = 1'b0;
      ans_nxt = 1'b0;
    end
    unique case (st_r)
      cfts_pkg::CFTS_IDLE: begin
        if (cfg_ok && (ans_r || pend_r || pend_rem_r)) begin
          req_nxt = 1'b1;
          ext_nxt = extended_id_select_i; // [RULE1]
          id_nxt = frame_id_i;
          len_nxt = payload_len_i;
          txd_nxt = wr_evt_i ? wr_data_i : pay_r; // [RULE16]
          // Answers to remote requests take precedence over own requests
          if (ans_r) begin
            rem_nxt = 1'b0;
            ans_nxt = rtr_rx_i;
          end else if (pend_r) begin
            rem_nxt = 1'b0;
            pend_nxt = wr_evt_i || cyc_due;
          end else begin
            rem_nxt = 1'b1;
            pend_rem_nxt = wr_evt_i || cyc_due;
          end
          st_nxt = cfts_pkg::CFTS_BUSY;
        end
      end
      cfts_pkg::CFTS_BUSY: begin
        if (tx_ack_i) begin
          req_nxt = 1'b0;
          gap_nxt = ivl;
          st_nxt = has_gap ? cfts_pkg::CFTS_GAP : cfts_pkg::CFTS_IDLE; // [RULE12] [RULE13]
        end
      end
      cfts_pkg::CFTS_GAP: begin
        if (tick) begin
          gap_nxt = gap_r - 16'h0001;
          if (gap_r <= 16'h0001) st_nxt = cfts_pkg::CFTS_IDLE; // [RULE12] [RULE16]
        end
      end
      default: begin
        st_nxt = cfts_pkg::CFTS_IDLE;
        req_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= cfts_pkg::CFTS_IDLE;
      per_r <= `CFTS_DEF_INTERVAL_TICKS;
      gap_r <= 16'h0000;
      pend_r <= 1'b0;
      pend_rem_r <= 1'b0;
      ans_r <= 1'b0;
      pay_r <= 64'h0000_0000_0000_0000;
      req_r <= 1'b0;
      rem_r <= 1'b0;
      ext_r <= 1'b0;
      id_r <= 29'h0000_0000;
      len_r <= 4'h0;
      txd_r <= 64'h0000_0000_0000_0000;
    end else begin
      st_r <= st_nxt;
      per_r <= per_nxt;
      gap_r <= gap_nxt;
      pend_r <= pend_nxt;
      pend_rem_r <= pend_rem_nxt;
      ans_r <= ans_nxt;
      pay_r <= pay_nxt;
      req_r <= req_nxt;
      rem_r <= rem_nxt;
      ext_r <= ext_nxt;
      id_r <= id_nxt;
      len_r <= len_nxt;
      txd_r <= txd_nxt;
    end
  end

  assign tx_req_o = req_r;
  assign tx_remote_o = rem_r;
  assign tx_ext_o = ext_r;
  assign tx_id_o = id_r;
  assign tx_len_o = len_r;
  assign tx_data_o = txd_r;
  assign cfg_ok_o = cfg_ok;

  gap_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE12]
    (st_r == cfts_pkg::CFTS_GAP) |=> !$rose(req_r))
    else $error("request raised during spacing");
  no_gap_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE13]
    (st_r == cfts_pkg::CFTS_BUSY && tx_ack_i && !has_gap) |=> st_r == cfts_pkg::CFTS_IDLE)
    else $error("zero spacing not honoured");
  data_ign_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE4]
    (mode == cfts_pkg::CFTS_CYC_DATA || mode == cfts_pkg::CFTS_EVT_DATA) |=> !ans_r)
    else $error("remote request seen in data mode");
  rem_ans_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE8]
    (cfg_ok && mode == cfts_pkg::CFTS_EVT_REM && rtr_rx_i && $stable(mode)) |=> ans_r)
    else $error("remote request not latched");
  bad_cfg_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE17]
    (!extended_id_select_i && frame_id_i > `CFTS_STD_ID_MAX) |=> !cfg_ok)
    else $error("bad standard id accepted");
  bad_len_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE18]
    (payload_len_i > `CFTS_MAX_LEN) |=> !cfg_ok)
    else $error("bad length accepted");
  req_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE3]
    (req_r && !tx_ack_i) |=> req_r && $stable(tx_id_o))
    else $error("request dropped before ack");
  evt_req_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RULE9]
    (cfg_ok && mode == cfts_pkg::CFTS_CYC_EVT && wr_evt_i && st_r == cfts_pkg::CFTS_IDLE
     && !ans_r && $stable(mode) && $stable(cfg_ok)) |-> ##[1:2] req_r)
    else $error("write not sent in combined mode");
endmodule
`default_nettype wire

// file: bench/cfts_can_node.sv
// Far-side CAN node model: acknowledges requested frames and issues remote requests
`default_nettype none
module cfts_can_node (
  input wire logic core_clk_i,      // System clock
  input wire logic rst_i,           // Synchronous reset
  input wire logic tx_req_i,        // Frame request from the scheduler
  input wire logic [2:0] ack_dly_i, // Cycles to wait before acknowledging
  input wire logic rtr_cmd_i,       // Bench asks for a remote request
  output logic tx_ack_o,            // Acknowledge pulse
  output logic rtr_rx_o             // Remote request pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_r <= 3'h0;
      tx_ack_o <= 1'b0;
      rtr_rx_o <= 1'b0;
    end else begin
      // Remote requests come from this side only when the bench commands them
      rtr_rx_o <= rtr_cmd_i;
      // Pulse lasts one cycle so a held request is never acknowledged twice
      if (tx_req_i && !tx_ack_o) begin
        if (cnt_r >= ack_dly_i) begin
          tx_ack_o <= 1'b1;
          cnt_r <= 3'h0;
        end else begin
          cnt_r <= cnt_r + 3'h1;
        end
      end else begin
        tx_ack_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking testbench for the frame transmit scheduler
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, dflt = 1'b0, ext = 1'b0, wr = 1'b0, rtr_cmd = 1'b0;
  logic [28:0] id = 29'h0000_0123;
  logic [2:0] code = 3'h1;
  logic [15:0] ivl = 16'h0002;
  logic [3:0] len = 4'h8;
  logic [63:0] wd = 64'h0;
  logic [2:0] dly = 3'h2;
  logic ack, rtr, req, rem, txe, cfg;
  logic [28:0] tid;
  logic [3:0] tlen;
  logic [63:0] tdat, d;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  int fails = 0, checks = 0, seed = 32'hde80, n;
  initial forever #50 clk = ~clk;
  cfts_sched cfts_sched_inst (.core_clk_i(clk), .rst_i(rst), .cfg_use_default_i(dflt),
    .extended_id_select_i(ext), .frame_id_i(id), .frame_timing_type_i(code),
    .frame_interval_time_i(ivl), .payload_len_i(len), .wr_evt_i(wr), .wr_data_i(wd),
    .rtr_rx_i(rtr), .tx_ack_i(ack), .tx_req_o(req), .tx_remote_o(rem), .tx_ext_o(txe),
    .tx_id_o(tid), .tx_len_o(tlen), .tx_data_o(tdat), .cfg_ok_o(cfg));
  cfts_can_node cfts_can_node_inst (.core_clk_i(clk), .rst_i(rst), .tx_req_i(req),
    .ack_dly_i(dly), .rtr_cmd_i(rtr_cmd), .tx_ack_o(ack), .rtr_rx_o(rtr));
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    checks++;
    if (got !== ex) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  function automatic logic cfg_exp(input logic x, input logic [28:0] i, input logic [2:0] c,
    input logic [15:0] v, input logic [3:0] l);
    cfg_exp = c <= 3'h4 && l <= 4'h8 && (x || i <= 29'h0000_07ff)
      && !(v == 16'h0 && c != 3'h1 && c != 3'h3);
  endfunction
  task automatic setc(input logic x, input logic [28:0] i, input logic [2:0] c,
    input logic [15:0] v, input logic [3:0] l);
    @(posedge clk);
    ext <= x;
    id <= i;
    code <= c;
    ivl <= v;
    len <= l;
    repeat (3) @(negedge clk);
    // With defaults selected the timing code and interval inputs are overridden
    chk("cfg_ok", {63'h0, cfg_exp(x, i, dflt ? 3'h1 : c, dflt ? 16'h00c8 : v, l)},
      {63'h0, cfg});
  endtask
  task automatic wev(input logic [63:0] dv);
    @(posedge clk);
    wr <= 1'b1;
    wd <= dv;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rtr_pulse;
    @(posedge clk);
    rtr_cmd <= 1'b1;
    @(posedge clk);
    rtr_cmd <= 1'b0;
  endtask
  task automatic wreq(output int c);
    c = 0;
    while (c < 12000 && req !== 1'b1) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic widle;
    for (int i = 0; i < 40 && req !== 1'b0; i++) @(negedge clk);
    chk("req_drop", 64'h0, {63'h0, req});
  endtask
  // Reference frames are compared at each acknowledged request
  always @(posedge clk) begin
    if (req === 1'b1 && ack === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected_frame", 64'h0, 64'h1);
      else begin
        e = exp_q.pop_front();
        chk("remote", {63'h0, e[64]}, {63'h0, rem});
        if (!e[64]) chk("data", e[63:0], tdat);
        chk("hdr", {30'h0, ext, len, id}, {30'h0, txe, tlen, tid});
      end
      dly <= 3'($random(seed));
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk("cfg_ok", 64'h1, {63'h0, cfg});
    exp_q.push_back({1'b0, 64'h1111_2222_3333_4444});
    wev(64'h1111_2222_3333_4444);
    wreq(n);
    chk("latency", 64'h1, {63'h0, n <= 3});
    widle();
    // Two early writes merge; only the later payload may go out
    wev(64'hdead_0000_0000_0001);
    wev(64'hbeef_0000_0000_0002);
    exp_q.push_back({1'b0, 64'hbeef_0000_0000_0002});
    wreq(n);
    chk("spacing", 64'h1, {63'h0, n >= 4900 && n <= 10010});
    widle();
    rtr_pulse();
    repeat (10100) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      setc(1'b1, 29'h1fff_ffff, k ? 3'h4 : 3'h1, k ? 16'h0002 : 16'h0000, 4'h3);
      for (int j = 0; j < 2; j++) begin
        d = {$random(seed), $random(seed)};
        exp_q.push_back({1'b0, d});
        wev(d);
        wreq(n);
        chk("back_to_back", 64'h1, {63'h0, n <= 3});
        widle();
      end
    end
    setc(1'b0, 29'h0000_07ff, 3'h3, 16'h0000, 4'h8);
    exp_q.push_back({1'b1, 64'h0});
    wev(64'h0123_4567_89ab_cdef);
    wreq(n);
    widle();
    for (int j = 0; j < 2; j++) begin
      exp_q.push_back({1'b0, 64'h0123_4567_89ab_cdef});
      rtr_pulse();
      wreq(n);
      chk("rtr_answer", 64'h1, {63'h0, n < 12000});
      widle();
    end
    for (int j = 0; j < 12; j++) begin
      setc(1'($random(seed)), ($random(seed) & 1) ? 29'h0000_0800 - 29'($random(seed) & 1)
        : 29'($random(seed)), 3'($random(seed)), 16'($random(seed) & 1), 4'($random(seed)));
    end
    @(posedge clk);
    dflt <= 1'b1;
    setc(1'b0, 29'h0000_0010, 3'h5, 16'h0000, 4'h2);
    chk("cfg_dflt", 64'h1, {63'h0, cfg});
    exp_q.push_back({1'b0, 64'h0000_0000_0000_5a5a});
    wev(64'h0000_0000_0000_5a5a);
    wreq(n);
    widle();
    wev(64'h0000_0000_0000_a5a5);
    wreq(n);
    chk("dflt_gap", 64'h1, {63'h0, n >= 12000});
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    dflt <= 1'b0;
    repeat (2) @(negedge clk);
    chk("req_reset", 64'h0, {63'h0, req});
    final_report();
  end
endmodule
`default_nettype wire
